/* cpw_center_pwm.sv */
// center aligned pwm output path with dead band and complementary pin
// assumes one timer clock, same-clock cross trigger, asynchronous pins
//
// Design decisions made here: the register addresses and the plain strobed port.
`timescale 1ns/100ps

// Function
// - zero, advance, reload conditions and repeat bit
// - period register sets period, compare sets duty
// - compare select bit enables match events
// - direction bit 1 makes pin an output
// - action register steers output per event
// - source 0 drives plain generator output
// - source 0xc drives dead band output
// - output disable bit 0 holds output low ahead of polarity
// - polarity inverts; idle level while stopped
// - enable bit starts counter and pwm
// - up match high, down match low
// - complementary pair never overlaps with dead band, except under complement force high, fault action high or inverted polarity
// - dead time register holds mode and delays
// - mode 0 delays both generator edges
// - mode 1 true output unchanged, delays complement
// - up/down period is twice period register
// - force codes: 0 none, 1 high, 2 low
module cpw_center_pwm #(
  parameter int CNT_W = 16
) (
  input  wire logic              ref_clk,
  input  wire logic              arst_n,
  input  wire cpw_pkg::cpw_req_s regReq,
  output logic [31:0]            regRdData,
  input  wire logic              crossTrig,
  input  wire logic              faultPin,
  input  wire logic              chPinIn,
  output logic                   chPinOut,
  output logic                   chPinOe_n,
  input  wire logic              cmplPinIn,
  output logic                   cmplPinOut,
  output logic                   cmplPinOe_n
);

  // ************************
  // registers
  // ************************
  cpw_pkg::cpw_ctr_ctl_s  counter_control_reg_reg;
  cpw_pkg::cpw_chan_ctl_s chanCtl_reg;
  cpw_pkg::cpw_action_s   action_reg;
  cpw_pkg::cpw_path_s     path_reg;
  cpw_pkg::cpw_deadtime_s deadtime_reg;
  logic [CNT_W-1:0]       period_reg;
  logic [CNT_W-1:0]       compare_reg;
  logic [CNT_W-1:0]       phase_reg;
  logic                   pinDir_reg;
  logic                   outEnable_reg;
  logic [CNT_W-1:0]       count_reg;
  cpw_pkg::cpw_state_e    state_reg;
  logic                   gen_reg;
  logic                   oneShotDone;
  logic [2:0]             syncIn;
  logic [2:0]             level_reg;

  wire logic wrStrobe = regReq.wrEn;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      counter_control_reg_reg    <= cpw_pkg::RST_WORD;
      chanCtl_reg   <= cpw_pkg::RST_WORD;
      action_reg    <= cpw_pkg::RST_WORD;
      path_reg      <= cpw_pkg::RST_WORD;
      deadtime_reg  <= cpw_pkg::RST_WORD;
      period_reg    <= CNT_W'(cpw_pkg::RST_WORD);
      compare_reg   <= CNT_W'(cpw_pkg::RST_WORD);
      phase_reg     <= CNT_W'(cpw_pkg::RST_WORD);
      pinDir_reg    <= 1'b0;
      outEnable_reg <= 1'b0;
    end else begin
      // one-shot end clears enable unless software writes the control register the same cycle
      if (oneShotDone) begin
        counter_control_reg_reg.enable <= 1'b0;
      end
      if (wrStrobe) begin
        unique case (regReq.addr)
          cpw_pkg::OFF_CTR_CTL:  counter_control_reg_reg <= cpw_pkg::cpw_ctr_ctl_s'({20'h0, regReq.wrData[11:0]});
          cpw_pkg::OFF_PERIOD:   period_reg <= regReq.wrData[CNT_W-1:0];
          cpw_pkg::OFF_COMPARE:  compare_reg <= regReq.wrData[CNT_W-1:0];
          cpw_pkg::OFF_CHAN_CTL: chanCtl_reg <= cpw_pkg::cpw_chan_ctl_s'({31'h0, regReq.wrData[0]});
          cpw_pkg::OFF_PIN_DIR:  pinDir_reg <= regReq.wrData[0];
          cpw_pkg::OFF_ACTION:   action_reg <= cpw_pkg::cpw_action_s'({18'h0, regReq.wrData[13:0]});
          cpw_pkg::OFF_PATH_CTL: path_reg <= cpw_pkg::cpw_path_s'({26'h0, regReq.wrData[5:0]});
          cpw_pkg::OFF_OUT_DIS:  outEnable_reg <= regReq.wrData[0];
          cpw_pkg::OFF_DEADTIME: deadtime_reg <= cpw_pkg::cpw_deadtime_s'({7'h0, regReq.wrData[24:0]});
          cpw_pkg::OFF_PHASE:    phase_reg <= regReq.wrData[CNT_W-1:0];
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      regRdData <= cpw_pkg::RST_WORD;
    end else if (regReq.rdEn) begin
      unique case (regReq.addr)
        cpw_pkg::OFF_CTR_CTL:  regRdData <= counter_control_reg_reg;
        cpw_pkg::OFF_PERIOD:   regRdData <= 32'(period_reg);
        cpw_pkg::OFF_COMPARE:  regRdData <= 32'(compare_reg);
        cpw_pkg::OFF_CHAN_CTL: regRdData <= chanCtl_reg;
        cpw_pkg::OFF_PIN_DIR:  regRdData <= {31'h0, pinDir_reg};
        cpw_pkg::OFF_ACTION:   regRdData <= action_reg;
        cpw_pkg::OFF_PATH_CTL: regRdData <= path_reg;
        cpw_pkg::OFF_OUT_DIS:  regRdData <= {31'h0, outEnable_reg};
        cpw_pkg::OFF_DEADTIME: regRdData <= deadtime_reg;
        cpw_pkg::OFF_PHASE:    regRdData <= 32'(phase_reg);
        cpw_pkg::OFF_STATUS:   regRdData <= cpw_pkg::cpw_status_s'({11'h0, level_reg[1:0], gen_reg,
                                                                   state_reg, 16'(count_reg)});
        default:               regRdData <= cpw_pkg::RST_WORD;
      endcase
    end else begin
      regRdData <= cpw_pkg::RST_WORD;
    end
  end

  // ************************
  // pin input synchronisers
  // ************************
  // bit 0 channel pin, bit 1 complementary pin, bit 2 fault pin
  wire logic [2:0] rawIn = {faultPin, cmplPinIn, chPinIn};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      logic stage2;
      logic stage3;
      always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
          syncIn[gi]    <= 1'b0;
          stage2        <= 1'b0;
          stage3        <= 1'b0;
          level_reg[gi] <= 1'b0;
        end else begin
          syncIn[gi] <= rawIn[gi];
          stage2     <= syncIn[gi];
          stage3     <= stage2;
          // a change counts only once two late stages agree
          if (stage2 == stage3) begin
            level_reg[gi] <= stage3;
          end
        end
      end
    end
  endgenerate

  wire logic faultActive = level_reg[2];

  // ************************
  // counter
  // ************************
  wire logic running    = (state_reg != cpw_pkg::ST_STOP);
  wire logic advance    = (counter_control_reg_reg.advanceCondCtl == cpw_pkg::COND_OFF) || crossTrig;
  wire logic zeroHit    = (counter_control_reg_reg.zeroCondCtl == cpw_pkg::COND_TRIG) && crossTrig;
  wire logic reloadHit  = (counter_control_reg_reg.reloadCondCtl == cpw_pkg::COND_TRIG) && crossTrig;
  wire logic atTop      = (count_reg >= period_reg);
  wire logic atZero     = (count_reg == '0);
  wire logic upDownMode = (counter_control_reg_reg.countModeSel == cpw_pkg::MODE_UPDOWN);
  wire logic periodEnd  = running && advance && !reloadHit && !zeroHit &&
                          ((state_reg == cpw_pkg::ST_UP && atTop && !upDownMode) ||
                           (state_reg == cpw_pkg::ST_DOWN && atZero));

  assign oneShotDone = periodEnd && !counter_control_reg_reg.repeatMode;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= cpw_pkg::ST_STOP;
      count_reg <= '0;
    end else if (!counter_control_reg_reg.enable) begin
      state_reg <= cpw_pkg::ST_STOP;
    end else begin
      unique case (state_reg)
        cpw_pkg::ST_STOP: begin
          state_reg <= (counter_control_reg_reg.countModeSel == cpw_pkg::MODE_DOWN) ? cpw_pkg::ST_DOWN : cpw_pkg::ST_UP;
          unique case (counter_control_reg_reg.valueAfterEnable)
            cpw_pkg::VAE_PERIOD: count_reg <= period_reg;
            cpw_pkg::VAE_PHASE:  count_reg <= phase_reg;
            cpw_pkg::VAE_ZERO:   count_reg <= '0;
            default: ;
          endcase
        end
        cpw_pkg::ST_UP, cpw_pkg::ST_DOWN: begin
          if (oneShotDone) begin
            state_reg <= cpw_pkg::ST_STOP;
          end else if (reloadHit) begin
            count_reg <= phase_reg;
          end else if (zeroHit) begin
            count_reg <= '0;
          end else if (advance && state_reg == cpw_pkg::ST_UP) begin
            if (!atTop) begin
              count_reg <= count_reg + 1'b1;
            end else if (upDownMode && !atZero) begin
              // turning at the top makes the full period twice the period value
              state_reg <= cpw_pkg::ST_DOWN;
              count_reg <= count_reg - 1'b1;
            end else if (!upDownMode) begin
              count_reg <= '0;
            end
          end else if (advance) begin
            if (!atZero) begin
              count_reg <= count_reg - 1'b1;
            end else if (upDownMode && period_reg != '0) begin
              state_reg <= cpw_pkg::ST_UP;
              count_reg <= count_reg + 1'b1;
            end else if (!upDownMode) begin
              count_reg <= period_reg;
            end
          end
        end
      endcase
    end
  end

  // ************************
  // event and signal generator
  // ************************
  wire logic matchEn  = running && chanCtl_reg.captureOrCompareSel;
  wire logic cmpHit   = (count_reg == compare_reg);
  wire logic cmpUp    = matchEn && cmpHit && state_reg == cpw_pkg::ST_UP;
  wire logic cmpDown  = matchEn && cmpHit && state_reg == cpw_pkg::ST_DOWN;
  wire logic zeroEvt  = running && atZero;
  wire logic loadEvt  = running && count_reg == period_reg;
  logic [1:0] evtAction;

  always_comb begin
    evtAction = cpw_pkg::ACT_NONE;
    if (cmpUp) begin
      evtAction = action_reg.upMatchAction;
    end else if (cmpDown) begin
      evtAction = action_reg.downMatchAction;
    end else if (matchEn && loadEvt) begin
      evtAction = action_reg.loadAction;
    end else if (matchEn && zeroEvt) begin
      evtAction = action_reg.zeroAction;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      gen_reg <= 1'b0;
    end else if (!running) begin
      gen_reg <= path_reg.idleOutputLevel;
    end else begin
      unique case (evtAction)
        cpw_pkg::ACT_HIGH:   gen_reg <= 1'b1;
        cpw_pkg::ACT_LOW:    gen_reg <= 1'b0;
        cpw_pkg::ACT_TOGGLE: gen_reg <= !gen_reg;
        default: ;
      endcase
    end
  end

  // software force replaces the generator before the dead band sees it
  function automatic logic applyForce(input logic [1:0] code, input logic lvl);
    return (code == cpw_pkg::FRC_HIGH) ? 1'b1 : (code == cpw_pkg::FRC_LOW) ? 1'b0 : lvl;
  endfunction

  wire logic genForced = applyForce(action_reg.swForceAction, gen_reg);

  // ************************
  // dead band
  // ************************
  wire logic       dtMode1 = deadtime_reg.deadtimeModeSel;
  wire logic [1:0] dbIn    = {!genForced, genForced};
  wire logic [11:0] dbDelay [2] = '{deadtime_reg.leadEdgeDelay, deadtime_reg.trailEdgeDelay};
  logic [1:0]      dbOut;
  logic            windowCmpl_reg;

  generate
    for (gi = 0; gi < 2; gi++) begin : g_edge_delay
      logic [11:0] delayCnt;
      logic        prevIn;
      always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
          delayCnt   <= 12'h000;
          prevIn     <= 1'b0;
          dbOut[gi]  <= 1'b0;
        end else begin
          prevIn <= dbIn[gi];
          if (!dbIn[gi]) begin
            // falling input ends the pulse at once, so the pair never overlaps
            dbOut[gi] <= 1'b0;
            delayCnt  <= 12'h000;
          end else if (!prevIn) begin
            delayCnt  <= dbDelay[gi];
            dbOut[gi] <= (dbDelay[gi] == 12'h000);
          end else if (delayCnt > 12'h001) begin
            delayCnt <= delayCnt - 12'h001;
          end else if (delayCnt == 12'h001) begin
            delayCnt  <= 12'h000;
            dbOut[gi] <= 1'b1;
          end
        end
      end
    end
  endgenerate

  // mode 1 leans on the up/down counter: complement opens a window around count zero, ending the delays short of the compare point
  wire logic [CNT_W:0] cntWide = {1'b0, count_reg};
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      windowCmpl_reg <= 1'b0;
    end else if (state_reg == cpw_pkg::ST_UP) begin
      windowCmpl_reg <= (cntWide + (CNT_W+1)'(deadtime_reg.leadEdgeDelay)) < {1'b0, compare_reg};
    end else begin
      // inclusive bound so a zero trail delay adds no gap after the generator falls
      windowCmpl_reg <= (cntWide + (CNT_W+1)'(deadtime_reg.trailEdgeDelay)) <= {1'b0, compare_reg};
    end
  end

  wire logic dbTrue = dtMode1 ? genForced : dbOut[0];
  wire logic dbCmpl = dtMode1 ? (windowCmpl_reg && !genForced) : dbOut[1];

  // ************************
  // output selection and pins
  // ************************
  logic srcTrue;
  logic srcCmpl;

  always_comb begin
    unique case (path_reg.outputSourceSel)
      cpw_pkg::SRC_GEN:      srcTrue = genForced;
      cpw_pkg::SRC_ZERO:     srcTrue = zeroEvt;
      cpw_pkg::SRC_LOAD:     srcTrue = loadEvt;
      cpw_pkg::SRC_CMP:      srcTrue = cmpUp || cmpDown;
      cpw_pkg::SRC_DEADBAND: srcTrue = dbTrue;
      default:               srcTrue = 1'b0;
    endcase
    srcCmpl = (path_reg.outputSourceSel == cpw_pkg::SRC_DEADBAND) ? dbCmpl : !srcTrue;
    srcCmpl = applyForce(action_reg.cmplForceAction, srcCmpl);
    if (faultActive && action_reg.faultAction != cpw_pkg::ACT_NONE) begin
      srcTrue = (action_reg.faultAction == cpw_pkg::ACT_HIGH);
      srcCmpl = srcTrue;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      chPinOut   <= 1'b0;
      cmplPinOut <= 1'b0;
    end else if (!running) begin
      chPinOut   <= path_reg.idleOutputLevel;
      cmplPinOut <= !path_reg.idleOutputLevel;
    end else begin
      // disable forces low ahead of the polarity stage
      chPinOut   <= (outEnable_reg && srcTrue) ^ path_reg.outputPolarity;
      cmplPinOut <= (outEnable_reg && srcCmpl) ^ path_reg.outputPolarity;
    end
  end

  assign chPinOe_n   = !pinDir_reg;
  assign cmplPinOe_n = !pinDir_reg;

  // ************************
  // assertions
  // ************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  sequence dbRiseHeld;
    ($rose(dbIn[0]) && !dtMode1 && deadtime_reg.leadEdgeDelay == 12'h002) ##1 dbIn[0] [*3];
  endsequence

  top_turn_a: assert property (running && upDownMode && advance && !reloadHit && !zeroHit && !oneShotDone &&
                               counter_control_reg_reg.enable && state_reg == cpw_pkg::ST_UP && count_reg == period_reg &&
                               period_reg != '0
                               |=> state_reg == cpw_pkg::ST_DOWN && count_reg == $past(period_reg) - 1'b1)
    else $error("up/down counter did not turn at the period value");
  zero_cond_a: assert property (running && counter_control_reg_reg.enable && zeroHit && !reloadHit && !oneShotDone |=> atZero)
    else $error("zero condition did not clear the counter");
  reload_cond_a: assert property (running && counter_control_reg_reg.enable && reloadHit && !oneShotDone
                                  |=> count_reg == $past(phase_reg))
    else $error("reload condition did not load the phase value");
  up_match_a: assert property (cmpUp && action_reg.upMatchAction == cpw_pkg::ACT_HIGH |=> gen_reg)
    else $error("up match did not drive the generator high");
  down_match_a: assert property (cmpDown && action_reg.downMatchAction == cpw_pkg::ACT_LOW |=> !gen_reg)
    else $error("down match did not drive the generator low");
  out_disable_a: assert property (running && !outEnable_reg && !path_reg.outputPolarity |=> !chPinOut)
    else $error("disabled output was not held low");
  idle_level_a: assert property (!running |=> chPinOut == $past(path_reg.idleOutputLevel))
    else $error("stopped output did not show the idle level");
  force_high_a: assert property (running && action_reg.swForceAction == cpw_pkg::FRC_HIGH && !faultActive &&
                                 path_reg.outputSourceSel == cpw_pkg::SRC_GEN && outEnable_reg &&
                                 !path_reg.outputPolarity |=> chPinOut)
    else $error("force high did not reach the pin");
  db_overlap_a: assert property (!dtMode1 |-> !(dbOut[0] && dbOut[1]))
    else $error("true and complementary dead band outputs overlap");
  lead_delay_a: assert property (dbRiseHeld |-> dbOut[0] && !$past(dbOut[0]))
    else $error("lead edge delay of two cycles not met");
  zero_delay_a: assert property ($rose(dbIn[0]) && deadtime_reg.leadEdgeDelay == 12'h000 |=> dbOut[0])
    else $error("zero delay still delayed the edge");
  mode_one_a: assert property (dtMode1 && running && path_reg.outputSourceSel == cpw_pkg::SRC_DEADBAND &&
                               outEnable_reg && !path_reg.outputPolarity && !faultActive
                               |=> chPinOut == $past(genForced))
    else $error("mode 1 true output differs from generator");
  enable_start_a: assert property (!running && counter_control_reg_reg.enable && !oneShotDone |=> running)
    else $error("enable did not start the counter");

endmodule // cpw_center_pwm

/* cpw_pkg.sv */
// package: register map, field layouts and codes of the center pwm block
// assumes a 32-bit plain register port and one 100 MHz timer clock
package cpw_pkg;

  // ************************
  // register offsets
  // ************************
  localparam logic [5:0] OFF_CTR_CTL  = 6'h00;
  localparam logic [5:0] OFF_PERIOD   = 6'h04;
  localparam logic [5:0] OFF_COMPARE  = 6'h08;
  localparam logic [5:0] OFF_CHAN_CTL = 6'h0c;
  localparam logic [5:0] OFF_PIN_DIR  = 6'h10;
  localparam logic [5:0] OFF_ACTION   = 6'h14;
  localparam logic [5:0] OFF_PATH_CTL = 6'h18;
  localparam logic [5:0] OFF_OUT_DIS  = 6'h1c;
  localparam logic [5:0] OFF_DEADTIME = 6'h20;
  localparam logic [5:0] OFF_PHASE    = 6'h24;
  localparam logic [5:0] OFF_STATUS   = 6'h28;

  // ************************
  // reset values and codes
  // ************************
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [1:0]  ACT_NONE   = 2'h0;
  localparam logic [1:0]  ACT_HIGH   = 2'h1;
  localparam logic [1:0]  ACT_LOW    = 2'h2;
  localparam logic [1:0]  ACT_TOGGLE = 2'h3;
  localparam logic [1:0]  FRC_NONE   = 2'h0;
  localparam logic [1:0]  FRC_HIGH   = 2'h1;
  localparam logic [1:0]  FRC_LOW    = 2'h2;
  localparam logic [1:0]  COND_OFF   = 2'h0;
  localparam logic [1:0]  COND_TRIG  = 2'h1;
  localparam logic [1:0]  VAE_PERIOD = 2'h0;
  localparam logic [1:0]  VAE_PHASE  = 2'h1;
  localparam logic [1:0]  VAE_ZERO   = 2'h2;
  localparam logic [3:0]  SRC_GEN    = 4'h0;
  localparam logic [3:0]  SRC_ZERO   = 4'h1;
  localparam logic [3:0]  SRC_LOAD   = 4'h2;
  localparam logic [3:0]  SRC_CMP    = 4'h3;
  localparam logic [3:0]  SRC_DEADBAND = 4'hc;

  typedef enum logic [1:0] {MODE_DOWN, MODE_UPDOWN, MODE_UP} cpw_mode_e;
  typedef enum logic [1:0] {ST_STOP, ST_UP, ST_DOWN} cpw_state_e;

  // ************************
  // field layouts
  // ************************
  typedef struct packed {
    logic [19:0] rsvd;
    logic [1:0]  valueAfterEnable;
    logic [1:0]  reloadCondCtl;
    logic [1:0]  advanceCondCtl;
    logic [1:0]  zeroCondCtl;
    logic        repeatMode;
    cpw_mode_e   countModeSel;
    logic        enable;
  } cpw_ctr_ctl_s;
  typedef struct packed {
    logic [30:0] rsvd;
    logic        captureOrCompareSel;
  } cpw_chan_ctl_s;
  typedef struct packed {
    logic [17:0] rsvd;
    logic [1:0]  cmplForceAction;
    logic [1:0]  swForceAction;
    logic [1:0]  faultAction;
    logic [1:0]  loadAction;
    logic [1:0]  zeroAction;
    logic [1:0]  downMatchAction;
    logic [1:0]  upMatchAction;
  } cpw_action_s;
  typedef struct packed {
    logic [25:0] rsvd;
    logic        idleOutputLevel;
    logic        outputPolarity;
    logic [3:0]  outputSourceSel;
  } cpw_path_s;
  typedef struct packed {
    logic [6:0]  rsvd;
    logic        deadtimeModeSel;
    logic [11:0] trailEdgeDelay;
    logic [11:0] leadEdgeDelay;
  } cpw_deadtime_s;
  typedef struct packed {
    logic [10:0] rsvd;
    logic [1:0]  pinLevel;
    logic        genLevel;
    cpw_state_e  runState;
    logic [15:0] count;
  } cpw_status_s;
  typedef struct packed {
    logic [5:0]  addr;
    logic [31:0] wrData;
    logic        wrEn;
    logic        rdEn;
  } cpw_req_s;
endpackage

/* cpw_bridge_model.sv */
// half-bridge gate stage seen from the true and complementary pins
// assumes gate inputs are pulled down whenever a pin is not driven
`timescale 1ns/100ps
module cpw_bridge_model (
  input  wire logic hiGate,
  input  wire logic hiOe_n,
  input  wire logic loGate,
  input  wire logic loOe_n,
  output logic      hiLevel,
  output logic      loLevel,
  output logic      shootThrough
);
  // ************************
  // pin levels
  // ************************
  // released pin falls to the pull-down, never the last driven value
  assign hiLevel = hiOe_n ? 1'b0 : hiGate;
  assign loLevel = loOe_n ? 1'b0 : loGate;
  // both switches on at once shorts the supply rail
  assign shootThrough = hiLevel & loLevel;
endmodule // cpw_bridge_model

/* tb_center_pwm_deadband_gen.sv */
// self-checking bench: register port master, bridge model on the pins
// assumes 100 MHz clock; high times counted over two full pwm periods
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checkCount++; if ((g) !== (e)) begin nErrors++; \
  $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module tb_center_pwm_deadband_gen;
  logic              ref_clk;
  logic              arst_n;
  cpw_pkg::cpw_req_s regReq;
  logic [31:0]       rdVal;
  logic [31:0]       regRdData;
  logic              chPinIn, chPinOut, chPinOe_n, cmplPinIn, cmplPinOut, cmplPinOe_n, shootThrough;
  logic              crossTrig, faultPin;
  int                nErrors, checkCount, seed, per, cmp, hi, chi, ov, lead, trail;

  cpw_center_pwm i_dut (.ref_clk(ref_clk), .arst_n(arst_n), .regReq(regReq), .regRdData(regRdData),
    .crossTrig(crossTrig), .faultPin(faultPin), .chPinIn(chPinIn), .chPinOut(chPinOut), .chPinOe_n(chPinOe_n),
    .cmplPinIn(cmplPinIn), .cmplPinOut(cmplPinOut), .cmplPinOe_n(cmplPinOe_n));
  cpw_bridge_model i_bridge (.hiGate(chPinOut), .hiOe_n(chPinOe_n), .loGate(cmplPinOut),
    .loOe_n(cmplPinOe_n), .hiLevel(chPinIn), .loLevel(cmplPinIn), .shootThrough(shootThrough));

  // ************************
  // bus and measurement tasks
  // ************************
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    regReq <= '{addr: a, wrData: d, wrEn: 1'b1, rdEn: 1'b0};
    @(posedge ref_clk);
    regReq.wrEn <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a);
    @(posedge ref_clk);
    regReq <= '{addr: a, wrData: 32'h0, wrEn: 1'b0, rdEn: 1'b1};
    @(posedge ref_clk);
    regReq.rdEn <= 1'b0;
    #1 rdVal = regRdData;
  endtask
  // window of exactly two periods, so the start phase does not matter
  task automatic meas;
    hi = 0;
    chi = 0;
    ov = 0;
    repeat (4 * per) @(posedge ref_clk);
    repeat (4 * per) begin
      @(posedge ref_clk);
      #1;
      hi += int'(chPinOut === 1'b1);
      chi += int'(cmplPinOut === 1'b1);
      ov += int'(shootThrough !== 1'b0);
    end
  endtask
  task automatic setup(input logic [31:0] path, input logic [31:0] dt);
    wr(cpw_pkg::OFF_CTR_CTL, 32'h0);
    wr(cpw_pkg::OFF_PERIOD, 32'(per));
    wr(cpw_pkg::OFF_COMPARE, 32'(cmp));
    wr(cpw_pkg::OFF_CHAN_CTL, 32'h1);
    wr(cpw_pkg::OFF_PIN_DIR, 32'h1);
    wr(cpw_pkg::OFF_ACTION, 32'h9);
    wr(cpw_pkg::OFF_PATH_CTL, path);
    wr(cpw_pkg::OFF_OUT_DIS, 32'h1);
    wr(cpw_pkg::OFF_DEADTIME, dt);
    wr(cpw_pkg::OFF_CTR_CTL, 32'h80b);
    meas();
  endtask
  task automatic testDone;
    $display("checks %0d mismatches %0d", checkCount, nErrors);
    if (nErrors == 0 && checkCount > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ************************
  // clock, watchdog, sequence
  // ************************
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (90000) @(posedge ref_clk);
    nErrors++;
    testDone();
  end
  initial begin
    seed = 29975;
    nErrors = 0;
    checkCount = 0;
    arst_n = 1'b0;
    regReq = '0;
    crossTrig = 1'b0;
    faultPin = 1'b0;
    repeat (3) @(posedge ref_clk);
    arst_n <= 1'b1;
    for (int a = 0; a <= 'h2c; a += 4) begin
      rd(6'(a));
      `CHK("reset word", 32'h0, rdVal)
    end
    per = 6 + int'({$random(seed)} % 8);
    cmp = 3 + int'({$random(seed)} % (per - 4));
    setup(32'h0, 32'h0);
    `CHK("ch high", 4 * (per - cmp), hi)
    `CHK("pin drive", 1'b0, chPinOe_n)
    rd(cpw_pkg::OFF_CTR_CTL);
    `CHK("ctr ctl", 32'h80b, rdVal)
    wr(cpw_pkg::OFF_PATH_CTL, 32'h10);
    meas();
    `CHK("inverted high", 4 * cmp, hi)
    wr(cpw_pkg::OFF_PATH_CTL, 32'h0);
    $display("test plain done");
    for (int f = 0; f < 3; f++) begin
      wr(cpw_pkg::OFF_ACTION, 32'h9 + 32'h1400 * 32'(f));
      meas();
      `CHK("forced ch", f == 1 ? 4 * per : f == 2 ? 0 : 4 * (per - cmp), hi)
      `CHK("forced cmpl", f == 1 ? 4 * per : f == 2 ? 0 : 4 * cmp, chi)
    end
    wr(cpw_pkg::OFF_ACTION, 32'h9);
    wr(cpw_pkg::OFF_CHAN_CTL, 32'h0);
    meas();
    `CHK("no events", 1'b1, (hi == 0) || (hi == 4 * per))
    wr(cpw_pkg::OFF_CHAN_CTL, 32'h1);
    wr(cpw_pkg::OFF_OUT_DIS, 32'h0);
    meas();
    `CHK("disabled low", 0, hi)
    wr(cpw_pkg::OFF_OUT_DIS, 32'h1);
    faultPin <= 1'b1;
    wr(cpw_pkg::OFF_ACTION, 32'h209);
    meas();
    `CHK("fault ch", 0, hi)
    `CHK("fault cmpl", 0, chi)
    faultPin <= 1'b0;
    $display("test force done");
    for (int i = 0; i < 4; i++) begin
      lead = i < 2 ? 0 : i == 2 ? 2 : 1 + int'({$random(seed)} % 2);
      trail = i < 2 ? 0 : 1 + int'({$random(seed)} % 2);
      setup(32'h0c, 32'(((i % 2) << 24) | (trail << 12) | lead));
      `CHK("overlap", 0, ov)
      `CHK("true width", 4 * (per - cmp) - ((i % 2) ? 0 : 2 * lead), hi)
      `CHK("cmpl width", 4 * cmp - 2 * trail - ((i % 2) ? 2 * lead : 0), chi)
      rd(cpw_pkg::OFF_DEADTIME);
      `CHK("dead time", 32'(((i % 2) << 24) | (trail << 12) | lead), rdVal)
    end
    $display("test dead band done");
    wr(cpw_pkg::OFF_PHASE, 32'h3);
    crossTrig <= 1'b1;
    wr(cpw_pkg::OFF_CTR_CTL, 32'h81b);
    rd(cpw_pkg::OFF_STATUS);
    `CHK("zeroed count", 16'h0, rdVal[15:0])
    wr(cpw_pkg::OFF_CTR_CTL, 32'h90b);
    rd(cpw_pkg::OFF_STATUS);
    `CHK("phase count", 16'h3, rdVal[15:0])
    crossTrig <= 1'b0;
    $display("test trigger done");
    wr(cpw_pkg::OFF_CTR_CTL, 32'h0);
    wr(cpw_pkg::OFF_PATH_CTL, 32'h20);
    meas();
    `CHK("idle level", 4 * per, hi)
    rd(cpw_pkg::OFF_STATUS);
    `CHK("stopped", 2'h0, rdVal[17:16])
    $display("test idle done");
    testDone();
  end
endmodule // tb_center_pwm_deadband_gen
